// File: include/smrw_cfg.svh
`ifndef SMRW_CFG_SVH
`define SMRW_CFG_SVH
// ==========================================
// geometry and widths
`define SMRW_NUM_CS 6
`define SMRW_CSW 3
`define SMRW_SETW 8
`define SMRW_PULW 9
`define SMRW_CYCW 10
// ==========================================
// data bus width codes
`define SMRW_DBW_8 2'h0
`define SMRW_DBW_16 2'h1
`define SMRW_DBW_32 2'h2
`endif

// File: include/smrw_pkg.sv
package smrw_pkg;
   typedef enum logic [1:0]
   {
      SMRW_IDLE = 2'b00,
      SMRW_RUN = 2'b01,
      SMRW_DONE = 2'b10
   } smrw_state_t;
endpackage : smrw_pkg

// File: design/smrw_wave_gen.sv
`timescale 1ns/1ps
`include "smrw_cfg.svh"
// per chip select read/write waveform generator for a static memory port
module smrw_wave_gen
(
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // request side
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic [`SMRW_CSW-1:0] req_cs,
   input wire logic [25:0] req_addr,
   input wire logic [31:0] req_wdata,
   input wire logic [3:0] req_be,
   output logic done_pulse,
   output logic [31:0] rd_data,
   // per chip select timing, flattened by chip select
   input wire logic [`SMRW_NUM_CS*`SMRW_SETW-1:0] rd_strobe_setup,
   input wire logic [`SMRW_NUM_CS*`SMRW_PULW-1:0] rd_strobe_pulse,
   input wire logic [`SMRW_NUM_CS*`SMRW_CYCW-1:0] rd_cycle_len,
   input wire logic [`SMRW_NUM_CS*`SMRW_SETW-1:0] cs_read_setup,
   input wire logic [`SMRW_NUM_CS*`SMRW_PULW-1:0] cs_read_pulse,
   input wire logic [`SMRW_NUM_CS*`SMRW_SETW-1:0] wr_strobe_setup,
   input wire logic [`SMRW_NUM_CS*`SMRW_PULW-1:0] wr_strobe_pulse,
   input wire logic [`SMRW_NUM_CS*`SMRW_CYCW-1:0] wr_cycle_len,
   input wire logic [`SMRW_NUM_CS*`SMRW_SETW-1:0] cs_write_setup,
   input wire logic [`SMRW_NUM_CS*`SMRW_PULW-1:0] cs_write_pulse,
   // per chip select mode bits
   input wire logic [`SMRW_NUM_CS-1:0] read_mode,
   input wire logic [`SMRW_NUM_CS-1:0] write_mode,
   input wire logic [`SMRW_NUM_CS-1:0] byte_write_mode,
   input wire logic [`SMRW_NUM_CS*2-1:0] data_width,
   // memory pins
   output logic [25:0] mem_addr,
   output logic [`SMRW_NUM_CS-1:0] chip_sel_n,
   output logic rd_strobe_n,
   output logic wr_strobe_n,
   output logic byte_wr_lane0_n,
   output logic byte_wr_lane1_n,
   output logic byte_wr_lane2_n,
   output logic byte_wr_lane3_n,
   output logic byte_sel_lane0_n,
   output logic byte_sel_lane1_n,
   output logic byte_sel_lane2_n,
   output logic byte_sel_lane3_n,
   input wire logic [31:0] mem_data_in,
   output logic [31:0] mem_data_out,
   output logic mem_data_oe
);
   // ==========================================
   // selected parameter set, chosen per chip select
   smrw_pkg::smrw_state_t state_q;
   smrw_pkg::smrw_state_t state_d;
   logic [`SMRW_CSW-1:0] cs_q;
   logic wr_q;
   logic [`SMRW_CYCW-1:0] cnt_q;
   logic [`SMRW_CYCW-1:0] cnt_d;
   logic [25:0] addr_q;
   logic [3:0] be_q;
   logic [31:0] wdata_q;
   logic [31:0] rdata_q;
   logic done_q;
   logic [`SMRW_SETW-1:0] st_setup;
   logic [`SMRW_PULW-1:0] st_pulse;
   logic [`SMRW_SETW-1:0] cs_setup;
   logic [`SMRW_PULW-1:0] cs_pulse;
   logic [`SMRW_CYCW-1:0] cyc_len;
   logic ctl_mode;
   logic bw_mode;
   logic [1:0] dbw;
   // per chip select selection of timing, never compared across strobes
   assign st_setup = wr_q ? wr_strobe_setup[cs_q*`SMRW_SETW +: `SMRW_SETW]
                          : rd_strobe_setup[cs_q*`SMRW_SETW +: `SMRW_SETW];
   assign st_pulse = wr_q ? wr_strobe_pulse[cs_q*`SMRW_PULW +: `SMRW_PULW]
                          : rd_strobe_pulse[cs_q*`SMRW_PULW +: `SMRW_PULW];
   assign cs_setup = wr_q ? cs_write_setup[cs_q*`SMRW_SETW +: `SMRW_SETW]
                          : cs_read_setup[cs_q*`SMRW_SETW +: `SMRW_SETW];
   assign cs_pulse = wr_q ? cs_write_pulse[cs_q*`SMRW_PULW +: `SMRW_PULW]
                          : cs_read_pulse[cs_q*`SMRW_PULW +: `SMRW_PULW];
   assign cyc_len = wr_q ? wr_cycle_len[cs_q*`SMRW_CYCW +: `SMRW_CYCW]
                         : rd_cycle_len[cs_q*`SMRW_CYCW +: `SMRW_CYCW];
   assign ctl_mode = wr_q ? write_mode[cs_q] : read_mode[cs_q];
   assign bw_mode = byte_write_mode[cs_q];
   assign dbw = data_width[cs_q*2 +: 2];

   // ==========================================
   // phase windows inside the cycle; hold is whatever is left of the cycle
   logic running;
   logic st_active;
   logic cs_active;
   logic [`SMRW_CYCW-1:0] st_end;
   logic [`SMRW_CYCW-1:0] cs_end;
   logic last_cnt;
   logic sample_now;
   logic drive_now;
   assign running = (state_q == smrw_pkg::SMRW_RUN);
   assign st_end = `SMRW_CYCW'(st_setup) + `SMRW_CYCW'(st_pulse);
   assign cs_end = `SMRW_CYCW'(cs_setup) + `SMRW_CYCW'(cs_pulse);
   assign st_active = running && (cnt_q >= `SMRW_CYCW'(st_setup))
                      && (cnt_q < st_end);
   assign cs_active = running && (cnt_q >= `SMRW_CYCW'(cs_setup))
                      && (cnt_q < cs_end);
   assign last_cnt = running && (cnt_q == cyc_len - `SMRW_CYCW'(1));
   // drivers on from end of setup of the governing strobe until cycle end
   assign drive_now = wr_q && running &&
                      (cnt_q >= `SMRW_CYCW'(ctl_mode ? st_setup : cs_setup));

   // ==========================================
   // back-to-back: a next access can be accepted in the done state, but the strobes
   // still return high for that cycle because nothing runs in the done state
   logic accept;
   assign req_ready = (state_q == smrw_pkg::SMRW_IDLE) ||
                      (state_q == smrw_pkg::SMRW_DONE);
   assign accept = req_valid && req_ready;

   // ==========================================
   // sequencer
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         smrw_pkg::SMRW_IDLE, smrw_pkg::SMRW_DONE:
         begin
            state_d = accept ? smrw_pkg::SMRW_RUN : smrw_pkg::SMRW_IDLE;
            cnt_d = '0;
         end
         smrw_pkg::SMRW_RUN:
         begin
            if (last_cnt)
            begin
               state_d = smrw_pkg::SMRW_DONE;
               cnt_d = '0;
            end
            else
            begin
               cnt_d = cnt_q + `SMRW_CYCW'(1);
            end
         end
         default:
         begin
            state_d = smrw_pkg::SMRW_IDLE;
            cnt_d = '0;
         end
      endcase
   end

   // state and counter
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q <= smrw_pkg::SMRW_IDLE;
         cnt_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // request capture; address held for the whole cycle
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cs_q <= '0;
         wr_q <= 1'b0;
         addr_q <= '0;
         be_q <= '0;
         wdata_q <= '0;
      end
      else if (accept)
      begin
         cs_q <= req_cs;
         wr_q <= req_write;
         addr_q <= req_addr;
         be_q <= req_be;
         wdata_q <= req_wdata;
      end
   end

   // read data capture on the governing strobe edge
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rdata_q <= '0;
      end
      else if (sample_now)
      begin
         rdata_q <= mem_data_in;
      end
   end

   // completion strobe after the pins have finished, so a zero-hold capture is in
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         done_q <= 1'b0;
      end
      else
      begin
         done_q <= (state_q == smrw_pkg::SMRW_DONE);
      end
   end

   // ==========================================
   // pin outputs, registered to keep them glitch free
   logic [25:0] addr_pin_d;
   logic [3:0] bsel_d;
   logic [3:0] bwr_d;
   logic [`SMRW_NUM_CS-1:0] cs_d;
   logic rd_d;
   logic we_d;
   logic oe_d;
   logic [25:0] addr_pin_q;
   logic [3:0] bsel_q;
   logic [3:0] bwr_q;
   logic [`SMRW_NUM_CS-1:0] cs_pin_q;
   logic rd_pin_q;
   logic we_pin_q;
   logic oe_q;
   logic [31:0] dout_q;
   logic [25:0] addr_trim;
   // width trimming: low address bits unused on wider buses
   assign addr_trim = (dbw == `SMRW_DBW_32) ? {addr_q[25:2], 2'b00} :
                      (dbw == `SMRW_DBW_16) ? {addr_q[25:1], 1'b0} : addr_q;
   // address stays between cycles so zero hold does not glitch it
   assign addr_pin_d = running ? addr_trim : addr_pin_q;
   // byte selects change with the address only, high when idle or in byte write mode
   assign bsel_d = (running && !bw_mode) ? ~be_q : 4'hf;
   // byte write lanes copy the write strobe timing
   assign bwr_d = (running && wr_q && bw_mode && st_active) ? ~be_q : 4'hf;
   assign we_d = !(wr_q && !bw_mode && st_active);
   assign rd_d = !(!wr_q && st_active);
   assign cs_d = cs_active ? ~(`SMRW_NUM_CS'(1) << cs_q) : {`SMRW_NUM_CS{1'b1}};
   assign oe_d = drive_now;
   // capture where the governing pin register goes high; pins lag the count by
   // one clock, so sampling from the count would cut a one-cycle pulse short
   logic st_pin_rise;
   logic cs_pin_rise;
   assign st_pin_rise = !rd_pin_q && rd_d;
   assign cs_pin_rise = !cs_pin_q[cs_q] && cs_d[cs_q];
   assign sample_now = !wr_q && (ctl_mode ? st_pin_rise : cs_pin_rise);

   // pin registers
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         addr_pin_q <= '0;
         bsel_q <= 4'hf;
         bwr_q <= 4'hf;
         cs_pin_q <= {`SMRW_NUM_CS{1'b1}};
         rd_pin_q <= 1'b1;
         we_pin_q <= 1'b1;
         oe_q <= 1'b0;
         dout_q <= '0;
      end
      else
      begin
         addr_pin_q <= addr_pin_d;
         bsel_q <= bsel_d;
         bwr_q <= bwr_d;
         cs_pin_q <= cs_d;
         rd_pin_q <= rd_d;
         we_pin_q <= we_d;
         oe_q <= oe_d;
         dout_q <= wr_q ? wdata_q : dout_q;
      end
   end

   // ==========================================
   // outputs
   assign mem_addr = addr_pin_q;
   assign chip_sel_n = cs_pin_q;
   assign rd_strobe_n = rd_pin_q;
   assign wr_strobe_n = we_pin_q;
   assign byte_sel_lane0_n = bsel_q[0];
   assign byte_sel_lane1_n = bsel_q[1];
   assign byte_sel_lane2_n = bsel_q[2];
   assign byte_sel_lane3_n = bsel_q[3];
   assign byte_wr_lane0_n = bwr_q[0];
   assign byte_wr_lane1_n = bwr_q[1];
   assign byte_wr_lane2_n = bwr_q[2];
   assign byte_wr_lane3_n = bwr_q[3];
   assign mem_data_out = dout_q;
   assign mem_data_oe = oe_q;
   assign rd_data = rdata_q;
   assign done_pulse = done_q;
endmodule : smrw_wave_gen

// File: bench/smrw_mem_model.sv
`timescale 1ns/1ps
// =====
// memory stand-in for the static port
module smrw_mem_model
#(
   parameter logic [31:0] STR_WORD = 32'h5a5a_0f0f,
   parameter logic [31:0] SEL_WORD = 32'h3c3c_a5a5
)
(
   // clock
   input wire logic core_clk,
   // pins from the controller
   input wire logic rd_strobe_n,
   input wire logic [5:0] chip_sel_n,
   input wire logic [31:0] mem_data_out,
   input wire logic mem_data_oe,
   // data back to the controller
   output logic [31:0] mem_data_in
);
   logic tog_q = 1'b0;
   // toggles so a late sample can never match a word
   always_ff @(posedge core_clk)
      tog_q <= ~tog_q;
   // word depends on which strobe is low; released bus is scrambled
   assign mem_data_in = mem_data_oe ? mem_data_out :
      !rd_strobe_n ? STR_WORD : !(&chip_sel_n) ? SEL_WORD : {16{tog_q, ~tog_q}};
endmodule : smrw_mem_model

// File: bench/smrw_wave_gen_asserts.sv
`timescale 1ns/1ps
`include "smrw_cfg.svh"
// =====
// pin level checks
module smrw_wave_gen_asserts
(
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // request side
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic done_pulse,
   input wire logic [31:0] rd_data,
   // memory pins
   input wire logic [25:0] mem_addr,
   input wire logic [`SMRW_NUM_CS-1:0] chip_sel_n,
   input wire logic rd_strobe_n,
   input wire logic wr_strobe_n,
   input wire logic mem_data_oe
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);
   property p_done_one;
      done_pulse |=> !done_pulse;
   endproperty
   a_done_one: assert property (p_done_one) else $error("done too long");
   property p_take_busy;
      req_valid && req_ready |=> !req_ready;
   endproperty
   a_take_busy: assert property (p_take_busy) else $error("still ready");
   property p_no_overlap;
      rd_strobe_n || wr_strobe_n;
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("both strobes low");
   property p_rd_released;
      !rd_strobe_n |-> !mem_data_oe;
   endproperty
   a_rd_released: assert property (p_rd_released) else $error("drive in read");
   property p_pins_busy;
      (!rd_strobe_n || !wr_strobe_n || !(&chip_sel_n)) |-> $past(!req_ready);
   endproperty
   a_pins_busy: assert property (p_pins_busy) else $error("pin low when idle");
   property p_oe_busy;
      mem_data_oe |-> $past(!req_ready);
   endproperty
   a_oe_busy: assert property (p_oe_busy) else $error("drive when idle");
   property p_cs_onehot;
      $onehot0(~chip_sel_n);
   endproperty
   a_cs_onehot: assert property (p_cs_onehot) else $error("two selects low");
   sequence s_rd_low2;
      !rd_strobe_n ##1 !rd_strobe_n;
   endsequence
   property p_addr_hold;
      s_rd_low2 |-> $stable(mem_addr);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved");
   property p_rdata_idle;
      rd_strobe_n && (&chip_sel_n) |=> $stable(rd_data);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("idle capture");
   c_oe: cover property (mem_data_oe);
   c_rd: cover property (!rd_strobe_n ##1 rd_strobe_n);
   c_wr: cover property (!wr_strobe_n ##1 wr_strobe_n);
endmodule : smrw_wave_gen_asserts

// File: bench/smrw_wave_gen_bench.sv
`timescale 1ns/1ps
`include "smrw_cfg.svh"
// =====
// bench for the waveform generator
module smrw_wave_gen_bench;
   localparam logic [31:0] W_STR = 32'h5a5a_0f0f;
   localparam logic [31:0] W_SEL = 32'h3c3c_a5a5;
   logic core_clk = 1'b0, arst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
   logic [2:0] req_cs = 3'h0;
   logic [25:0] req_addr = 26'h0, mem_addr, aq;
   logic [31:0] req_wdata = 32'h0, rd_data, mem_data_in, mem_data_out, dq;
   logic [3:0] req_be = 4'hf;
   logic [47:0] rd_strobe_setup = '0, cs_read_setup = '0, wr_strobe_setup = '0;
   logic [47:0] cs_write_setup = '0;
   logic [53:0] rd_strobe_pulse = '0, cs_read_pulse = '0, wr_strobe_pulse = '0;
   logic [53:0] cs_write_pulse = '0;
   logic [59:0] rd_cycle_len = '0, wr_cycle_len = '0;
   logic [5:0] read_mode = 6'h01, write_mode = 6'h01, byte_write_mode = 6'h02, chip_sel_n;
   logic [11:0] data_width = 12'h008;
   logic req_ready, done_pulse, rd_strobe_n, wr_strobe_n, mem_data_oe;
   logic byte_wr_lane0_n, byte_wr_lane1_n, byte_sel_lane0_n;
   int err_total = 0, check_count = 0, lat, rdl, wrl, csl, oel, bw0, bw1, bs0;
   // free running clock
   always #4 core_clk = ~core_clk;
   smrw_wave_gen i_dut (.core_clk, .arst_n, .req_valid, .req_ready, .req_write, .req_cs,
      .req_addr, .req_wdata, .req_be, .done_pulse, .rd_data, .rd_strobe_setup,
      .rd_strobe_pulse, .rd_cycle_len, .cs_read_setup, .cs_read_pulse, .wr_strobe_setup,
      .wr_strobe_pulse, .wr_cycle_len, .cs_write_setup, .cs_write_pulse, .read_mode,
      .write_mode, .byte_write_mode, .data_width, .mem_addr, .chip_sel_n, .rd_strobe_n,
      .wr_strobe_n, .byte_wr_lane0_n, .byte_wr_lane1_n, .byte_wr_lane2_n(),
      .byte_wr_lane3_n(), .byte_sel_lane0_n, .byte_sel_lane1_n(), .byte_sel_lane2_n(),
      .byte_sel_lane3_n(), .mem_data_in, .mem_data_out, .mem_data_oe);
   smrw_mem_model #(.STR_WORD(W_STR), .SEL_WORD(W_SEL)) i_mem (.core_clk, .rd_strobe_n,
      .chip_sel_n, .mem_data_out, .mem_data_oe, .mem_data_in);
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e)
      begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test
   // per select timing: read strobe, read select, write strobe, write select
   task automatic cfg(input int c, rs, rp, rc, ss, sp, ws, wp, wc, ts, tp);
      rd_strobe_setup[c*8+:8] <= 8'(rs);
      rd_strobe_pulse[c*9+:9] <= 9'(rp);
      rd_cycle_len[c*10+:10] <= 10'(rc);
      cs_read_setup[c*8+:8] <= 8'(ss);
      cs_read_pulse[c*9+:9] <= 9'(sp);
      wr_strobe_setup[c*8+:8] <= 8'(ws);
      wr_strobe_pulse[c*9+:9] <= 9'(wp);
      wr_cycle_len[c*10+:10] <= 10'(wc);
      cs_write_setup[c*8+:8] <= 8'(ts);
      cs_write_pulse[c*9+:9] <= 9'(tp);
   endtask : cfg
   // one access; counts low cycles of the strobes, the selected chip select and the watched byte lanes, and drive cycles, until done
   task automatic acc(input logic w, input logic [2:0] c, input logic [25:0] a,
      input logic [31:0] d, input logic [3:0] be);
      {lat, rdl, wrl, csl, oel, bw0, bw1, bs0} = '0;
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_cs <= c;
      req_addr <= a;
      req_wdata <= d;
      req_be <= be;
      @(posedge core_clk);
      req_valid <= 1'b0;
      do
      begin
         @(negedge core_clk);
         lat++;
         rdl += int'(rd_strobe_n === 1'b0);
         wrl += int'(wr_strobe_n === 1'b0);
         bw0 += int'(byte_wr_lane0_n === 1'b0);
         bw1 += int'(byte_wr_lane1_n === 1'b0);
         bs0 += int'(byte_sel_lane0_n === 1'b0);
         csl += int'(chip_sel_n[c] === 1'b0);
         if (chip_sel_n[c] === 1'b0)
            aq = mem_addr;
         if (mem_data_oe === 1'b1)
         begin
            oel++;
            dq = mem_data_out;
         end
      end
      while (done_pulse !== 1'b1 && lat < 300);
   endtask : acc
   // hang guard, far beyond the roughly fifty cycles needed
   initial
   begin
      #20000;
      err_total++;
      end_of_test();
   end
   // main sequence
   initial
   begin
      repeat (2) @(posedge core_clk);
      chk({rd_strobe_n, wr_strobe_n, &chip_sel_n, mem_data_oe}, 4'he);
      arst_n <= 1'b1;
      cfg(0, 2, 3, 8, 1, 6, 1, 3, 6, 0, 5);
      cfg(1, 1, 2, 7, 1, 5, 1, 4, 6, 2, 2);
      acc(1'b0, 3'h0, 26'h0000123, 32'h0, 4'hf);
      chk(lat, 10);
      chk(rdl, 3);
      chk(csl, 6);
      chk(oel, 0);
      chk(rd_data, W_STR);
      chk(aq, 26'h0000123);
      $display("test 1 done");
      acc(1'b0, 3'h1, 26'h0000127, 32'h0, 4'hf);
      chk(lat, 9);
      chk(rdl, 2);
      chk(csl, 5);
      chk(rd_data, W_SEL);
      chk(aq, 26'h0000124);
      $display("test 2 done");
      acc(1'b1, 3'h0, 26'h0000040, 32'hcafe_0001, 4'hf);
      chk(lat, 8);
      chk(wrl, 3);
      chk(bs0, 6);
      chk(csl, 5);
      chk(oel, 5);
      chk(dq, 32'hcafe_0001);
      $display("test 3 done");
      acc(1'b1, 3'h1, 26'h0000080, 32'h1234_abcd, 4'h1);
      chk(lat, 8);
      chk(bw0, 4);
      chk(wrl, 0);
      chk(bs0, 0);
      chk(bw1, 0);
      chk(csl, 2);
      chk(oel, 4);
      chk(dq, 32'h1234_abcd);
      chk({rd_strobe_n, wr_strobe_n, &chip_sel_n, mem_data_oe}, 4'he);
      $display("test 4 done");
      // zero setup and hold, one-cycle pulse: capture lands on the last pin cycle
      cfg(0, 0, 1, 1, 0, 1, 1, 3, 6, 0, 5);
      acc(1'b0, 3'h0, 26'h0000200, 32'h0, 4'hf);
      chk(lat, 3);
      chk(rdl, 1);
      chk(csl, 1);
      chk(rd_data, W_STR);
      chk(aq, 26'h0000200);
      $display("test 5 done");
      end_of_test();
   end
endmodule : smrw_wave_gen_bench
bind smrw_wave_gen smrw_wave_gen_asserts i_chk (.core_clk, .arst_n, .req_valid, .req_ready,
   .done_pulse, .rd_data, .mem_addr, .chip_sel_n, .rd_strobe_n, .wr_strobe_n, .mem_data_oe);
